// ===== rtl/iasf_consts.svh
// Offsets, field positions and reset values of the ack and status flag block.
`ifndef IASF_CONSTS_SVH
`define IASF_CONSTS_SVH

// Register byte offsets.
`define IASF_OFS_ENABLE   4'h0
`define IASF_OFS_STATUS   4'h4
`define IASF_OFS_TXHOLD   4'h8
`define IASF_OFS_RXHOLD   4'hC

// Field positions in the enable register.
`define IASF_BIT_TXE_IE   7
`define IASF_BIT_TXEND_IE 6
`define IASF_BIT_RXF_IE   5
`define IASF_BIT_ACKCHK   2
`define IASF_BIT_ACKRX    1
`define IASF_BIT_ACKTX    0

// Field positions in the status register.
`define IASF_BIT_TXE      7
`define IASF_BIT_TXEND    6
`define IASF_BIT_RXF      5

// Reset values.
`define IASF_RST_BIT      1'h0
`define IASF_RST_BYTE     8'h00

`endif

// ===== rtl/iasf_pkg.sv
// Types shared by the ack and status flag block.
package iasf_pkg;

	// One register bus request.
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} iasf_bus_req_s;

	// One-cycle event pulses and levels from the serial shift engine.
	typedef struct packed {
		logic hold_to_shift;
		logic transmit_select_set;
		logic start_issued;
		logic slave_to_tx;
		logic ninth_rise;
		logic frame_done;
		logic rx_load;
		logic ack_sample;
		logic ack_in;
		logic ack_slot;
	} iasf_evt_s;

endpackage

// ===== rtl/iasf_top.sv
// Acknowledge control, status flags and interrupts of a two-mode serial unit.
// What this block does
// - Received nack halts transfer when checking enabled.
// - Transmit mode captures receiver ack, read-only.
// - Receive mode drives sent ack value in slot.
// - Holding-to-shift move sets transmit empty flag.
// - Transmit select or start also set it.
// - Slave receive-to-transmit switch sets it.
// - Read one then write zero clears it.
// - Holding register write clears empty and end.
// - I2C format: ninth clock rise with empty sets end.
// - Synchronous format: last bit out sets end.
// - Read one then write zero clears end.
// - Shift-to-receive-holding move sets full flag.
// - Read one then write zero clears full.
// - Reading receive holding register clears full.
// - Empty flag and enable request empty interrupt.
// - End flag and enable request end interrupt.
// - Full flag and enable request full interrupt.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "iasf_consts.svh"

module iasf_top (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// Register bus.
	input  wire iasf_pkg::iasf_bus_req_s bus_req,
	output logic [7:0]                  bus_rdata,
	// Serial shift engine.
	input  wire iasf_pkg::iasf_evt_s    evt,
	input  wire logic                   i2c_format,
	input  wire logic                   tx_mode,
	input  wire logic [7:0]             rx_byte,
	output logic [7:0]                  tx_byte,
	output logic                        tx_hold_full,
	output logic                        halt_transfer,
	output logic                        ack_bit_out,
	output logic                        ack_bit_oe,
	// Interrupts.
	output logic                        tx_empty_irq,
	output logic                        tx_end_irq,
	output logic                        rx_full_irq,
	output logic                        irq
);
	import iasf_pkg::*;

	// Interrupt enables and ack control written by software, and the received ack bit captured from the bus.
	logic       tx_empty_irq_enable_reg;
	logic       tx_end_irq_enable_reg;
	logic       rx_full_irq_enable_reg;
	logic       ack_check_enable_reg;
	logic       received_ack_bit_reg;
	logic       sent_ack_value_reg;

	// Status flags and their read-one arming.
	logic       transmit_buffer_empty_flag_reg;
	logic       transmit_end_flag_reg;
	logic       receive_buffer_full_flag_reg;
	logic [2:0] armed_reg;

	// Data holding and halt state.
	logic [7:0] txhold_reg;
	logic [7:0] rxhold_reg;
	logic [7:0] rdata_reg;
	logic       hfull_reg;
	logic       halt_reg;

	// Decoded strobes and flag update requests.
	logic       wr_en;
	logic       wr_st;
	logic       wr_tx;
	logic       rd_st;
	logic       rd_rx;
	logic       clr_tx_empty;
	logic       clr_tx_end;
	logic       clr_rx_full;
	logic       set_tx_empty;
	logic       set_tx_end;
	logic       set_rx_full;
	logic [7:0] enable_view;
	logic [7:0] status_view;

	// Address decode of the strobes.
	assign wr_en = bus_req.wr && bus_req.addr == `IASF_OFS_ENABLE;
	assign wr_st = bus_req.wr && bus_req.addr == `IASF_OFS_STATUS;
	assign wr_tx = bus_req.wr && bus_req.addr == `IASF_OFS_TXHOLD;
	assign rd_st = bus_req.rd && bus_req.addr == `IASF_OFS_STATUS;
	assign rd_rx = bus_req.rd && bus_req.addr == `IASF_OFS_RXHOLD;

	// Register images as software sees them; unheld bits read as zero.
	always_comb begin
		enable_view = `IASF_RST_BYTE;
		enable_view[`IASF_BIT_TXE_IE]   = tx_empty_irq_enable_reg;
		enable_view[`IASF_BIT_TXEND_IE] = tx_end_irq_enable_reg;
		enable_view[`IASF_BIT_RXF_IE]   = rx_full_irq_enable_reg;
		enable_view[`IASF_BIT_ACKCHK]   = ack_check_enable_reg;
		enable_view[`IASF_BIT_ACKRX]    = received_ack_bit_reg;
		enable_view[`IASF_BIT_ACKTX]    = sent_ack_value_reg;
		status_view = `IASF_RST_BYTE;
		status_view[`IASF_BIT_TXE]   = transmit_buffer_empty_flag_reg;
		status_view[`IASF_BIT_TXEND] = transmit_end_flag_reg;
		status_view[`IASF_BIT_RXF]   = receive_buffer_full_flag_reg;
	end

	// Flag set conditions from the shift engine.
	assign set_tx_empty = evt.hold_to_shift
		|| evt.transmit_select_set || evt.start_issued
		|| evt.slave_to_tx;
	assign set_tx_end = (i2c_format && evt.ninth_rise && transmit_buffer_empty_flag_reg)
		|| (!i2c_format && evt.frame_done);
	assign set_rx_full = evt.rx_load;

	// A zero written to an armed flag clears it; a one or an unarmed zero does not.
	assign clr_tx_empty = (wr_st && !bus_req.wdata[`IASF_BIT_TXE] && armed_reg[2])
		|| wr_tx;
	assign clr_tx_end = (wr_st && !bus_req.wdata[`IASF_BIT_TXEND] && armed_reg[1])
		|| wr_tx;
	assign clr_rx_full = (wr_st && !bus_req.wdata[`IASF_BIT_RXF] && armed_reg[0])
		|| rd_rx;

	// A status read arms each flag that it saw as one; a status write disarms all.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			armed_reg <= 3'h0;
		end else if (rd_st) begin
			armed_reg <= armed_reg | status_view[7:5];
		end else if (wr_st) begin
			armed_reg <= 3'h0;
		end else begin
			armed_reg <= armed_reg & status_view[7:5];
		end
	end

	// Transmit empty flag; a set in the clearing cycle wins.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			transmit_buffer_empty_flag_reg <= `IASF_RST_BIT;
		end else if (set_tx_empty) begin
			transmit_buffer_empty_flag_reg <= 1'h1;
		end else if (clr_tx_empty) begin
			transmit_buffer_empty_flag_reg <= 1'h0;
		end
	end

	// Transmit end flag; a set in the clearing cycle wins.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			transmit_end_flag_reg <= `IASF_RST_BIT;
		end else if (set_tx_end) begin
			transmit_end_flag_reg <= 1'h1;
		end else if (clr_tx_end) begin
			transmit_end_flag_reg <= 1'h0;
		end
	end

	// Receive full flag; a set in the clearing cycle wins.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			receive_buffer_full_flag_reg <= `IASF_RST_BIT;
		end else if (set_rx_full) begin
			receive_buffer_full_flag_reg <= 1'h1;
		end else if (clr_rx_full) begin
			receive_buffer_full_flag_reg <= 1'h0;
		end
	end

	// Software-written enable and ack control bits.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_empty_irq_enable_reg <= `IASF_RST_BIT;
			tx_end_irq_enable_reg   <= `IASF_RST_BIT;
			rx_full_irq_enable_reg  <= `IASF_RST_BIT;
			ack_check_enable_reg    <= `IASF_RST_BIT;
			sent_ack_value_reg      <= `IASF_RST_BIT;
		end else if (wr_en) begin
			tx_empty_irq_enable_reg <= bus_req.wdata[`IASF_BIT_TXE_IE];
			tx_end_irq_enable_reg   <= bus_req.wdata[`IASF_BIT_TXEND_IE];
			rx_full_irq_enable_reg  <= bus_req.wdata[`IASF_BIT_RXF_IE];
			ack_check_enable_reg    <= bus_req.wdata[`IASF_BIT_ACKCHK];
			sent_ack_value_reg      <= bus_req.wdata[`IASF_BIT_ACKTX];
		end
	end

	// Received ack bit: captured in transmit mode only, never written by software.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			received_ack_bit_reg <= `IASF_RST_BIT;
		end else if (evt.ack_sample && tx_mode) begin
			received_ack_bit_reg <= evt.ack_in;
		end
	end

	// Halt request: a nack with checking on stops the next transfer until a
	// new byte or a new start restarts it.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			halt_reg <= `IASF_RST_BIT;
		end else if (evt.ack_sample && tx_mode && ack_check_enable_reg && evt.ack_in) begin
			halt_reg <= 1'h1;
		end else if (wr_tx || evt.start_issued) begin
			halt_reg <= 1'h0;
		end
	end

	// Transmit holding register and its occupancy for the shift engine.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			txhold_reg <= `IASF_RST_BYTE;
		end else if (wr_tx) begin
			txhold_reg <= bus_req.wdata;
		end
	end

	// The holding register counts as full from a software write until the move.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			hfull_reg <= `IASF_RST_BIT;
		end else if (wr_tx) begin
			hfull_reg <= 1'h1;
		end else if (evt.hold_to_shift) begin
			hfull_reg <= 1'h0;
		end
	end

	// Receive holding register loaded from the shift register.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rxhold_reg <= `IASF_RST_BYTE;
		end else if (evt.rx_load) begin
			rxhold_reg <= rx_byte;
		end
	end

	// Read data, valid in the cycle after the read strobe only.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_reg <= `IASF_RST_BYTE;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				`IASF_OFS_ENABLE: rdata_reg <= enable_view;
				`IASF_OFS_STATUS: rdata_reg <= status_view;
				`IASF_OFS_RXHOLD: rdata_reg <= rxhold_reg;
				default:          rdata_reg <= `IASF_RST_BYTE;
			endcase
		end else begin
			rdata_reg <= `IASF_RST_BYTE;
		end
	end

	// Outputs to the bus and the shift engine.
	assign bus_rdata     = rdata_reg;
	assign tx_byte       = txhold_reg;
	assign tx_hold_full  = hfull_reg;
	assign halt_transfer = halt_reg;

	// The ack level stands all the time; the enable opens it only in a receive slot.
	assign ack_bit_out   = sent_ack_value_reg;
	assign ack_bit_oe    = evt.ack_slot && !tx_mode;

	// Interrupt requests follow flag and enable as levels.
	assign tx_empty_irq = transmit_buffer_empty_flag_reg && tx_empty_irq_enable_reg;
	assign tx_end_irq   = transmit_end_flag_reg && tx_end_irq_enable_reg;
	assign rx_full_irq  = receive_buffer_full_flag_reg && rx_full_irq_enable_reg;
	assign irq          = tx_empty_irq || tx_end_irq || rx_full_irq;

	// Checks on the flag and ack behaviour.
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);

	// Ack control.
	halt_on_nack_a: assert property (
		evt.ack_sample && tx_mode && ack_check_enable_reg && evt.ack_in |=> halt_transfer)
		else $error("nack with checking on did not halt");
	no_halt_unchecked_a: assert property (
		!halt_transfer && !ack_check_enable_reg |=> !halt_transfer)
		else $error("halt raised while checking off");
	ack_capture_a: assert property (
		evt.ack_sample && tx_mode |=> received_ack_bit_reg == $past(evt.ack_in))
		else $error("received ack not captured");
	ack_drive_a: assert property (
		evt.ack_slot && !tx_mode |-> ack_bit_oe && ack_bit_out == sent_ack_value_reg)
		else $error("ack slot level wrong");
	ack_quiet_tx_a: assert property (
		tx_mode |-> !ack_bit_oe)
		else $error("ack driven in transmit mode");

	// Transmit empty flag.
	empty_set_a: assert property (
		evt.hold_to_shift |=> transmit_buffer_empty_flag_reg)
		else $error("empty flag not set on move");
	hold_free_a: assert property (
		evt.hold_to_shift && !wr_tx |=> !tx_hold_full)
		else $error("holding register still full after move");
	empty_other_set_a: assert property (
		evt.transmit_select_set || evt.start_issued || evt.slave_to_tx
		|=> transmit_buffer_empty_flag_reg)
		else $error("empty flag not set on mode event");
	empty_clear_a: assert property (
		rd_st && transmit_buffer_empty_flag_reg ##1 wr_st && !bus_req.wdata[7] && !set_tx_empty
		|=> !transmit_buffer_empty_flag_reg)
		else $error("armed zero write did not clear empty");
	txhold_write_a: assert property (
		wr_tx && !set_tx_empty && !set_tx_end
		|=> !transmit_buffer_empty_flag_reg && !transmit_end_flag_reg)
		else $error("holding write did not clear flags");

	// Transmit end flag.
	end_set_a: assert property (
		i2c_format && evt.ninth_rise && transmit_buffer_empty_flag_reg |=> transmit_end_flag_reg)
		else $error("end flag not set on ninth rise");
	end_sync_a: assert property (
		!i2c_format && evt.frame_done |=> transmit_end_flag_reg)
		else $error("end flag not set on last bit");
	end_clear_a: assert property (
		rd_st && transmit_end_flag_reg ##1 wr_st && !bus_req.wdata[6] && !set_tx_end
		|=> !transmit_end_flag_reg)
		else $error("armed zero write did not clear end");

	// Receive full flag, and an unarmed status write keeping the empty flag.
	full_set_a: assert property (
		evt.rx_load |=> receive_buffer_full_flag_reg && rxhold_reg == $past(rx_byte))
		else $error("full flag or data wrong on load");
	full_clear_a: assert property (
		rd_st && receive_buffer_full_flag_reg ##1 wr_st && !bus_req.wdata[5] && !set_rx_full
		|=> !receive_buffer_full_flag_reg)
		else $error("armed zero write did not clear full");
	full_read_a: assert property (
		rd_rx && !set_rx_full |=> !receive_buffer_full_flag_reg)
		else $error("receive read did not clear full");
	unarmed_keep_a: assert property (
		wr_st && armed_reg == 3'h0 && !wr_tx
		|=> transmit_buffer_empty_flag_reg >= $past(transmit_buffer_empty_flag_reg))
		else $error("unarmed write cleared empty flag");

	// Interrupt levels.
	irq_level_a: assert property (
		irq == (tx_empty_irq || tx_end_irq || rx_full_irq))
		else $error("interrupt level wrong");
	end_irq_a: assert property (
		tx_end_irq |-> transmit_end_flag_reg && tx_end_irq_enable_reg)
		else $error("end interrupt without cause");
	full_irq_a: assert property (
		receive_buffer_full_flag_reg && rx_full_irq_enable_reg |-> rx_full_irq)
		else $error("full interrupt missing");

	// Main scenarios.
	nack_halt_c: cover property (halt_transfer && irq);
	clear_cycle_c: cover property (rd_st && receive_buffer_full_flag_reg ##1 wr_st
		##1 !receive_buffer_full_flag_reg);
	set_beats_clear_c: cover property (set_tx_empty && clr_tx_empty);
	halt_restart_c: cover property (halt_transfer ##1 !halt_transfer);
	sync_end_c: cover property (!i2c_format && evt.frame_done ##1 transmit_end_flag_reg);

endmodule // iasf_top

// ===== sim/iasf_engine.sv
// Behavioural model of the serial shift engine that reports events.
`timescale 1ns/100ps

module iasf_engine (
	// Clock and reset.
	input  wire logic                clk,
	input  wire logic                rstn,
	// Requests from the bench and events to the block.
	input  wire iasf_pkg::iasf_evt_s req,
	output iasf_pkg::iasf_evt_s      evt
);
	import iasf_pkg::*;

	// Each requested event is reported one clock later, as a shifter would.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			evt <= '0;
		end else begin
			evt <= req;
		end
	end
endmodule // iasf_engine

// ===== sim/testbench.sv
// Self-checking bench for the ack control and status flag block.
`timescale 1ns/100ps
`include "iasf_consts.svh"

module testbench;
	import iasf_pkg::*;
	logic          clk, rstn, i2c_format, tx_mode, tx_hold_full, halt_transfer;
	logic          ack_bit_out, ack_bit_oe, tx_empty_irq, tx_end_irq, rx_full_irq, irq;
	logic [7:0]    bus_rdata, rx_byte, tx_byte, d;
	iasf_bus_req_s bus_req;
	iasf_evt_s     req, evt;
	int            n_errors, comparisons;

	iasf_engine eng (.clk(clk), .rstn(rstn), .req(req), .evt(evt));
	iasf_top dut (.clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.evt(evt), .i2c_format(i2c_format), .tx_mode(tx_mode), .rx_byte(rx_byte),
		.tx_byte(tx_byte), .tx_hold_full(tx_hold_full), .halt_transfer(halt_transfer),
		.ack_bit_out(ack_bit_out), .ack_bit_oe(ack_bit_oe), .tx_empty_irq(tx_empty_irq),
		.tx_end_irq(tx_end_irq), .rx_full_irq(rx_full_irq), .irq(irq));

	// Compares a seen value with the expected one and counts both outcomes.
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One write cycle; results are settled when it returns.
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		bus_req <= '{addr:a, wdata:v, wr:1'b1, rd:1'b0};
		@(posedge clk);
		bus_req <= '0;
		#1;
	endtask

	// One read cycle; data are taken in the cycle after the strobe.
	task rc(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus_req <= '{addr:a, wdata:8'h00, wr:1'b0, rd:1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 d = bus_rdata;
		chk(d, exp);
	endtask

	// Asks the engine for one event pulse and waits until the block took it.
	task ev(input iasf_evt_s e);
		@(posedge clk);
		req <= e;
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		#1;
	endtask

	// Raises an event, reads the status, clears it by read-then-write-zero.
	task setclr(input iasf_evt_s e, input logic [7:0] exp);
		ev(e);
		rc(`IASF_OFS_STATUS, exp);
		wr(`IASF_OFS_STATUS, 8'h00);
		rc(`IASF_OFS_STATUS, 8'h00);
	endtask

	// Prints the verdict and ends the run.
	task end_of_test;
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Cuts a hung run short.
	initial begin
		#100000;
		n_errors++;
		end_of_test;
	end

	// Main sequence of scenarios.
	initial begin
		rstn = 1'b0; bus_req = '0; req = '0; i2c_format = 1'b1; tx_mode = 1'b1;
		rx_byte = 8'h00; n_errors = 0; comparisons = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rc(`IASF_OFS_ENABLE, 8'h00);
		rc(`IASF_OFS_STATUS, 8'h00);
		chk(irq, 8'h00);
		wr(`IASF_OFS_ENABLE, 8'hFF);
		rc(`IASF_OFS_ENABLE, 8'hE5);
		wr(`IASF_OFS_ENABLE, 8'h00);
		wr(4'h2, 8'hFF);
		rc(4'h2, 8'h00);
		rc(`IASF_OFS_TXHOLD, 8'h00);
		wr(`IASF_OFS_TXHOLD, 8'hA5);
		chk({tx_hold_full, tx_byte[6:0]}, 8'hA5);
		ev('{hold_to_shift:1'b1, default:1'b0});
		chk(tx_hold_full, 8'h00);
		chk(irq, 8'h00);
		wr(`IASF_OFS_STATUS, 8'h00);
		rc(`IASF_OFS_STATUS, 8'h80);
		wr(`IASF_OFS_ENABLE, 8'h80);
		chk({tx_empty_irq, irq}, 8'h03);
		wr(`IASF_OFS_STATUS, 8'hFF);
		rc(`IASF_OFS_STATUS, 8'h80);
		wr(`IASF_OFS_STATUS, 8'h00);
		rc(`IASF_OFS_STATUS, 8'h00);
		chk({tx_empty_irq, irq}, 8'h00);
		setclr('{transmit_select_set:1'b1, default:1'b0}, 8'h80);
		setclr('{start_issued:1'b1, default:1'b0}, 8'h80);
		setclr('{slave_to_tx:1'b1, default:1'b0}, 8'h80);
		ev('{ninth_rise:1'b1, default:1'b0});
		rc(`IASF_OFS_STATUS, 8'h00);
		ev('{transmit_select_set:1'b1, default:1'b0});
		wr(`IASF_OFS_ENABLE, 8'h40);
		ev('{ninth_rise:1'b1, default:1'b0});
		rc(`IASF_OFS_STATUS, 8'hC0);
		chk({tx_end_irq, irq}, 8'h03);
		wr(`IASF_OFS_TXHOLD, 8'h3C);
		rc(`IASF_OFS_STATUS, 8'h00);
		chk(tx_end_irq, 8'h00);
		chk(tx_byte, 8'h3C);
		i2c_format <= 1'b0;
		ev('{transmit_select_set:1'b1, default:1'b0});
		ev('{ninth_rise:1'b1, default:1'b0});
		rc(`IASF_OFS_STATUS, 8'h80);
		wr(`IASF_OFS_STATUS, 8'h00);
		setclr('{frame_done:1'b1, default:1'b0}, 8'h40);
		rx_byte <= 8'h55;
		wr(`IASF_OFS_ENABLE, 8'h20);
		ev('{rx_load:1'b1, default:1'b0});
		chk({rx_full_irq, irq}, 8'h03);
		rc(`IASF_OFS_RXHOLD, 8'h55);
		rc(`IASF_OFS_STATUS, 8'h00);
		chk(irq, 8'h00);
		setclr('{rx_load:1'b1, default:1'b0}, 8'h20);
		wr(`IASF_OFS_ENABLE, 8'h04);
		ev('{ack_sample:1'b1, ack_in:1'b1, default:1'b0});
		chk(halt_transfer, 8'h01);
		rc(`IASF_OFS_ENABLE, 8'h06);
		wr(`IASF_OFS_TXHOLD, 8'h11);
		chk(halt_transfer, 8'h00);
		wr(`IASF_OFS_ENABLE, 8'h00);
		ev('{ack_sample:1'b1, ack_in:1'b1, default:1'b0});
		chk(halt_transfer, 8'h00);
		ev('{ack_sample:1'b1, default:1'b0});
		rc(`IASF_OFS_ENABLE, 8'h00);
		tx_mode <= 1'b0;
		ev('{ack_sample:1'b1, ack_in:1'b1, default:1'b0});
		rc(`IASF_OFS_ENABLE, 8'h00);
		wr(`IASF_OFS_ENABLE, 8'h01);
		@(posedge clk);
		req <= '{ack_slot:1'b1, default:1'b0};
		repeat (2) @(posedge clk);
		#1 chk({ack_bit_oe, ack_bit_out}, 8'h03);
		wr(`IASF_OFS_ENABLE, 8'h00);
		chk({ack_bit_oe, ack_bit_out}, 8'h02);
		@(posedge clk);
		req <= '0;
		end_of_test;
	end
endmodule // testbench
